// ### common/odl_link_if.sv
`timescale 1ns/10ps
interface odl_link_if;
  logic frame_sync_n;
  logic serial_clock_in;
  logic serial_data_in;
  logic serial_data_out;
  logic load_all_n;
  logic clear_outputs_n;

  modport dev (
    input  frame_sync_n,
    input  serial_clock_in,
    input  serial_data_in,
    output serial_data_out,
    input  load_all_n,
    input  clear_outputs_n
  );

  modport host (
    output frame_sync_n,
    output serial_clock_in,
    output serial_data_in,
    input  serial_data_out,
    output load_all_n,
    output clear_outputs_n
  );
endinterface

// ### common/odl_pkg.sv
package odl_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int WORD_BITS     = 16;
  localparam int CODE_BITS     = 12;
  localparam int CHAN_COUNT    = 8;
  localparam int CODE_MSB_POS  = 15;
  localparam int CODE_LSB_POS  = 4;
  localparam int ADDR_BIT_POS  = 3;
  localparam int SEL_MSB_POS   = 2;
  localparam int SEL_LSB_POS   = 0;
  localparam int SEL_BITS      = 3;
  localparam int CNT_BITS      = 6;
  localparam logic [CNT_BITS-1:0] BITS_PER_WORD  = 6'h10;
  localparam logic [CNT_BITS-1:0] BITS_LONG_WORD = 6'h20;

  typedef logic [CODE_BITS-1:0]                 odl_code_t;
  typedef logic [CHAN_COUNT-1:0][CODE_BITS-1:0] odl_bank_t;
  typedef logic [WORD_BITS-1:0]                 odl_word_t;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam odl_code_t CODE_RST = 12'h000;
  localparam odl_word_t WORD_RST = 16'h0000;
  // Sync order: clear, load, addr, data, frame, clock
  localparam logic [5:0] PIN_SYNC_RST = 6'h33;

  // ****************************************************************
  // Link timing at 40 MHz
  // ****************************************************************
  localparam int PCLK_PERIOD_NS = 25;
  localparam int SCLK_HALF_NS   = 100;
  localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int FRAME_SETUP_NS = 30;
  localparam int FRAME_SETUP_CYC = (FRAME_SETUP_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int FRAME_HOLD_NS  = 90;
  localparam int FRAME_HOLD_CYC = (FRAME_HOLD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int TIMER_BITS     = 4;

  // ****************************************************************
  // Host controller register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TXWORD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RXWORD = 8'h0c;
  localparam int CTRL_LOAD_POS   = 0;
  localparam int CTRL_CLEAR_POS  = 1;
  localparam int CTRL_LONG_POS   = 2;
  localparam int STATUS_BUSY_POS = 0;
  localparam logic [2:0] CTRL_RST = 3'h0;

  typedef enum logic [3:0] {
    HST_IDLE  = 4'h1,
    HST_SETUP = 4'h2,
    HST_RUN   = 4'h4,
    HST_HOLD  = 4'h8
  } odl_host_state_e;

endpackage

// ### testbench/odl_properties.sv
`timescale 1ns/10ps
module odl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_sync_n,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic load_all_n,
  input wire logic clear_outputs_n
);
  // ****
  // Frame tracking
  // ****
  logic        clk_q;
  logic        past16;
  logic [5:0]  falls;
  logic [15:0] rx_sr;
  wire         fall_seen = clk_q & ~serial_clock_in;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b1;
      falls <= 6'h00;
    end else begin
      clk_q <= serial_clock_in;
      falls <= frame_sync_n ? 6'h00 : falls + 6'(fall_seen);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sr <= 16'h0000;
    end else if (!frame_sync_n && fall_seen && falls < 6'h10) begin
      rx_sr <= {rx_sr[14:0], serial_data_in};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      past16 <= 1'b0;
    end else if (!frame_sync_n && falls == 6'h00) begin
      past16 <= 1'b0;
    end else if (falls == 6'h10) begin
      past16 <= 1'b1;
    end
  end

  // ****
  // Link checks
  // ****
  a_clk_idle_high: assert property (frame_sync_n |-> serial_clock_in)
    else $error("link clock low outside a frame");
  a_frame_setup: assert property ($fell(frame_sync_n) |-> serial_clock_in [*4])
    else $error("clock fell too soon after frame start");
  a_frame_hold: assert property ($rose(frame_sync_n) |-> $past(serial_clock_in, 4))
    else $error("frame closed too soon after last rise");
  a_low_phase: assert property ($fell(serial_clock_in) |-> (!serial_clock_in) [*4] ##1 serial_clock_in)
    else $error("link clock low phase wrong");
  a_data_steady: assert property (!frame_sync_n && !serial_clock_in |-> $stable(serial_data_in))
    else $error("serial data moved while clock low");
  a_word_len: assert property ($rose(frame_sync_n) |-> falls == 6'h10 || falls == 6'h20)
    else $error("frame length not a whole word");
  a_out_after_word: assert property ($changed(serial_data_out) |-> past16)
    else $error("serial output moved before a full word");
  a_chain_bit: assert property (!frame_sync_n && $rose(serial_clock_in) && falls > 6'h10
    |-> serial_data_out == rx_sr[4'(6'h20 - falls)])
    else $error("chained bit differs from received word");
  a_reset_idle: assert property ($rose(presetn) |-> load_all_n && clear_outputs_n && frame_sync_n)
    else $error("link not idle after reset");
endmodule

// ### testbench/odl_tb.sv
`timescale 1ns/10ps
module octal_dac_serial_loader_tb;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               addr_pin;
  logic               addr_pin_b;
  logic               taken;
  odl_pkg::odl_bank_t in_lat;
  odl_pkg::odl_bank_t dac_lat;
  odl_pkg::odl_bank_t in_lat_b;
  odl_pkg::odl_bank_t exp_in;
  int                 fail_count;
  int                 cmp_count;
  int                 taken_cnt;
  logic [15:0]        w;

  odl_link_if link ();
  odl_link_if link_b ();

  odl_host u_odl_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  odl_device u_odl_device (.pclk(pclk), .presetn(presetn), .link(link), .device_addr_pin(addr_pin),
    .input_latch(in_lat), .dac_latch(dac_lat), .word_taken(taken));
  odl_device u_odl_device_b (.pclk(pclk), .presetn(presetn), .link(link_b), .device_addr_pin(addr_pin_b),
    .input_latch(in_lat_b), .dac_latch(), .word_taken());
  odl_properties u_odl_properties (.pclk(pclk), .presetn(presetn), .frame_sync_n(link.frame_sync_n),
    .serial_clock_in(link.serial_clock_in), .serial_data_in(link.serial_data_in),
    .serial_data_out(link.serial_data_out), .load_all_n(link.load_all_n),
    .clear_outputs_n(link.clear_outputs_n));

  always #12.5 pclk = ~pclk;

  always @(posedge pclk) begin
    if (taken === 1'b1) begin
      taken_cnt++;
    end
  end

  // ****
  // Tasks
  // ****
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bank(input string what, input odl_pkg::odl_bank_t exp, input odl_pkg::odl_bank_t got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, d, r, x);
    chk("pslverr", {31'h0, e}, {31'h0, x});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] r;
    logic        x;
    apb(1'b0, a, 32'h0, r, x);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, e}, {31'h0, x});
  endtask

  task automatic send(input logic [15:0] word);
    logic [31:0] r;
    logic        x;
    wr(odl_pkg::REG_TXWORD, {16'h0, word}, 1'b0);
    r = 32'h1;
    for (int i = 0; i < 400 && r[0] !== 1'b0; i++) begin
      apb(1'b0, odl_pkg::REG_STATUS, 32'h0, r, x);
    end
    chk("busy", 32'h0, {31'h0, r[0]});
    repeat (4) @(posedge pclk);
  endtask

  task automatic drive_b(input logic [31:0] bits, input int n, input logic frm);
    @(posedge pclk);
    link_b.frame_sync_n <= frm;
    for (int i = 31; i > 31 - n; i--) begin
      link_b.serial_data_in <= bits[i];
      link_b.serial_clock_in <= 1'b1;
      repeat (4) @(posedge pclk);
      link_b.serial_clock_in <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    link_b.serial_clock_in <= 1'b1;
    link_b.serial_data_in <= ~link_b.serial_data_in;
    repeat (4) @(posedge pclk);
    link_b.frame_sync_n <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  function automatic logic [15:0] mk(input logic [11:0] c, input logic a, input logic [2:0] s);
    return {c, a, s};
  endfunction

  task automatic ctrl_then_check(input logic [31:0] c, input odl_pkg::odl_bank_t exp);
    wr(odl_pkg::REG_CTRL, c, 1'b0);
    repeat (8) @(posedge pclk);
    chk_bank("dac latch", exp, dac_lat);
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****
  // Tests
  // ****
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    addr_pin = 1'b0;
    addr_pin_b = 1'b1;
    {link_b.frame_sync_n, link_b.serial_clock_in, link_b.serial_data_in} = 3'h6;
    {link_b.load_all_n, link_b.clear_outputs_n} = 2'h3;
    fail_count = 0;
    cmp_count = 0;
    taken_cnt = 0;
    exp_in = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(odl_pkg::REG_CTRL, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    wr(odl_pkg::REG_STATUS, 32'h1, 1'b1);
    for (int ch = 0; ch < 8; ch++) begin
      exp_in[ch] = {3'(ch), ~3'(ch), 6'h15};
      send(mk(exp_in[ch], 1'b0, 3'(ch)));
    end
    chk_bank("input latch", exp_in, in_lat);
    send(mk(12'hfff, 1'b1, 3'h0));
    chk_bank("input latch", exp_in, in_lat);
    chk("words taken", 32'h8, 32'(taken_cnt));
    addr_pin <= 1'b1;
    exp_in[5] = 12'h5c3;
    send(mk(12'h5c3, 1'b1, 3'h5));
    chk_bank("input latch", exp_in, in_lat);
    wr(odl_pkg::REG_CTRL, 32'h4, 1'b0);
    w = mk(12'hc69, 1'b0, 3'h2);
    send(w);
    rd(odl_pkg::REG_RXWORD, {16'h0, w}, 1'b0);
    chk_bank("input latch", exp_in, in_lat);
    chk("words taken", 32'h9, 32'(taken_cnt));
    ctrl_then_check(32'h0, '0);
    ctrl_then_check(32'h1, exp_in);
    ctrl_then_check(32'h2, '0);
    chk_bank("input latch", exp_in, in_lat);
    ctrl_then_check(32'h3, '0);
    ctrl_then_check(32'h1, exp_in);
    wr(odl_pkg::REG_CTRL, 32'h0, 1'b0);
    drive_b({mk(12'h7e1, 1'b1, 3'h3), 16'h0}, 10, 1'b0);
    chk_bank("second input latch", '0, in_lat_b);
    drive_b({mk(12'h7e1, 1'b1, 3'h3), 16'h0}, 16, 1'b1);
    chk_bank("second input latch", '0, in_lat_b);
    drive_b({mk(12'h2d4, 1'b1, 3'h2), mk(12'h9b7, 1'b1, 3'h5)}, 32, 1'b0);
    chk_bank("second input latch", {96'h0} | (96'h2d4 << 24), in_lat_b);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end
endmodule

// ### verilog/odl_device.sv
`timescale 1ns/10ps

// How it works
// - Sample serial data on serial clock falls
// - Shift only while frame sync held low
// - Sixteenth fall loads matching word's code
// - Sixteen bits, code MSB first
// - Address bit sits at word bit 3
// - Last three bits select the channel
// - Address mismatch discards word, latches unchanged
// - Received word goes out serially on clock rises while frame stays low past sixteen bits
// - Serial output taken from shift register
// - Load low copies all input latches unless clear is low
// - Clear low forces converter latches zero
// - After sixteen bits, wait for frame fall
// - Bits 2..0 index channels A to H
// - Clear leaves input latches untouched
module odl_device (
  input  wire  logic             pclk,
  input  wire  logic             presetn,
  odl_link_if.dev                link,
  input  wire  logic             device_addr_pin,
  output odl_pkg::odl_bank_t     input_latch,
  output odl_pkg::odl_bank_t     dac_latch,
  output logic                   word_taken
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [5:0] pin_raw;
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;

  assign pin_raw = {link.clear_outputs_n, link.load_all_n, device_addr_pin,
                    link.serial_data_in, link.frame_sync_n, link.serial_clock_in};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_meta_reg[gi] <= odl_pkg::PIN_SYNC_RST[gi];
          pin_sync_reg[gi] <= odl_pkg::PIN_SYNC_RST[gi];
        end else begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  logic sclk_s;
  logic frame_n_s;
  logic serial_data_in_s;
  logic addr_s;
  logic load_n_s;
  logic clear_n_s;

  assign sclk_s    = pin_sync_reg[0];
  assign frame_n_s = pin_sync_reg[1];
  assign serial_data_in_s    = pin_sync_reg[2];
  assign addr_s    = pin_sync_reg[3];
  assign load_n_s  = pin_sync_reg[4];
  assign clear_n_s = pin_sync_reg[5];

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  logic sclk_d_reg;
  logic frame_n_d_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_reg    <= 1'b1;
      frame_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg    <= sclk_s;
      frame_n_d_reg <= frame_n_s;
    end
  end

  logic sclk_fall;
  logic sclk_rise;
  logic frame_fall;

  assign sclk_fall  = sclk_d_reg & ~sclk_s;
  assign sclk_rise  = ~sclk_d_reg & sclk_s;
  assign frame_fall = frame_n_d_reg & ~frame_n_s;

  // ****************************************************************
  // Bit counter
  // ****************************************************************
  logic [odl_pkg::CNT_BITS-1:0] bit_cnt_reg;
  logic                         shift_en;
  logic                         last_bit;

  // Shifting stays enabled only within a frame and below sixteen bits
  assign shift_en = ~frame_n_s & (bit_cnt_reg < odl_pkg::BITS_PER_WORD);
  assign last_bit = shift_en & sclk_fall
                    & (bit_cnt_reg == odl_pkg::BITS_PER_WORD - 6'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg <= '0;
    end else if (frame_fall) begin
      bit_cnt_reg <= '0;
    end else if (shift_en && sclk_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
  end

  // ****************************************************************
  // Input shift register
  // ****************************************************************
  odl_pkg::odl_word_t shift_reg;
  odl_pkg::odl_word_t word_next;
  logic               out_phase;

  // Newest bit enters at the bottom so the first bit ends up as the MSB
  assign word_next = {shift_reg[odl_pkg::WORD_BITS-2:0], serial_data_in_s};
  assign out_phase = ~frame_n_s & (bit_cnt_reg == odl_pkg::BITS_PER_WORD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= odl_pkg::WORD_RST;
    end else if (shift_en && sclk_fall) begin
      shift_reg <= word_next;
    end else if (out_phase && sclk_rise) begin
      shift_reg <= {shift_reg[odl_pkg::WORD_BITS-2:0], 1'b0};
    end
  end

  // ****************************************************************
  // Daisy-chain output
  // ****************************************************************
  logic serial_data_out_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_data_out_reg <= 1'b0;
    end else if (out_phase && sclk_rise) begin
      serial_data_out_reg <= shift_reg[odl_pkg::WORD_BITS-1];
    end
  end

  assign link.serial_data_out = serial_data_out_reg;

  // ****************************************************************
  // Word decode
  // ****************************************************************
  odl_pkg::odl_code_t         rx_code;
  logic                       rx_addr;
  logic [odl_pkg::SEL_BITS-1:0] rx_sel;
  logic                       addr_match;

  assign rx_code    = word_next[odl_pkg::CODE_MSB_POS:odl_pkg::CODE_LSB_POS];
  assign rx_addr    = word_next[odl_pkg::ADDR_BIT_POS];
  assign rx_sel     = word_next[odl_pkg::SEL_MSB_POS:odl_pkg::SEL_LSB_POS];
  assign addr_match = (rx_addr == addr_s);

  // ****************************************************************
  // Input latches
  // ****************************************************************
  generate
    for (gi = 0; gi < odl_pkg::CHAN_COUNT; gi++) begin : g_in
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          input_latch[gi] <= odl_pkg::CODE_RST;
        end else if (last_bit && addr_match && (rx_sel == odl_pkg::SEL_BITS'(gi))) begin
          input_latch[gi] <= rx_code;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_taken <= 1'b0;
    end else begin
      word_taken <= last_bit & addr_match;
    end
  end

  // ****************************************************************
  // Converter latches
  // ****************************************************************
  generate
    for (gi = 0; gi < odl_pkg::CHAN_COUNT; gi++) begin : g_dac
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dac_latch[gi] <= odl_pkg::CODE_RST;
        end else if (!clear_n_s) begin
          dac_latch[gi] <= odl_pkg::CODE_RST;
        end else if (!load_n_s) begin
          dac_latch[gi] <= input_latch[gi];
        end
      end
    end
  endgenerate

endmodule

// ### verilog/odl_host.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module odl_host (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  odl_link_if.host          link
);

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic                   apb_wr;
  logic                   apb_rd;
  logic                   busy;
  logic [2:0]             ctrl_reg;
  odl_pkg::odl_word_t     tx_reg;
  odl_pkg::odl_word_t     rx_reg;
  logic                   start;
  logic                   mapped;

  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign mapped  = (paddr == odl_pkg::REG_CTRL) | (paddr == odl_pkg::REG_TXWORD)
                   | (paddr == odl_pkg::REG_STATUS) | (paddr == odl_pkg::REG_RXWORD);
  assign start   = apb_wr & (paddr == odl_pkg::REG_TXWORD) & ~busy;
  assign pslverr = psel & penable & (~mapped | (pwrite & (paddr == odl_pkg::REG_TXWORD) & busy)
                   | (pwrite & (paddr == odl_pkg::REG_STATUS)) | (pwrite & (paddr == odl_pkg::REG_RXWORD)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= odl_pkg::CTRL_RST;
    end else if (apb_wr && paddr == odl_pkg::REG_CTRL) begin
      ctrl_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_reg <= odl_pkg::WORD_RST;
    end else if (start) begin
      tx_reg <= pwdata[odl_pkg::WORD_BITS-1:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_rd) begin
      unique case (paddr)
        odl_pkg::REG_CTRL:   prdata = {29'h0, ctrl_reg};
        odl_pkg::REG_TXWORD: prdata = {16'h0, tx_reg};
        odl_pkg::REG_STATUS: prdata = {31'h0, busy};
        odl_pkg::REG_RXWORD: prdata = {16'h0, rx_reg};
        default:             prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Static link levels
  // ****************************************************************
  assign link.load_all_n      = ~ctrl_reg[odl_pkg::CTRL_LOAD_POS];
  assign link.clear_outputs_n = ~ctrl_reg[odl_pkg::CTRL_CLEAR_POS];

  // ****************************************************************
  // Daisy-chain input synchroniser
  // ****************************************************************
  logic sdo_meta_reg;
  logic sdo_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_meta_reg <= 1'b0;
      sdo_sync_reg <= 1'b0;
    end else begin
      sdo_meta_reg <= link.serial_data_out;
      sdo_sync_reg <= sdo_meta_reg;
    end
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  odl_pkg::odl_host_state_e        state_reg;
  logic [odl_pkg::TIMER_BITS-1:0]  timer_reg;
  logic [odl_pkg::CNT_BITS-1:0]    fall_cnt_reg;
  logic [odl_pkg::CNT_BITS-1:0]    frame_len_reg;
  logic                            sclk_reg;
  logic                            frame_n_reg;
  odl_pkg::odl_word_t              out_reg;
  logic                            tick;

  localparam logic [odl_pkg::TIMER_BITS-1:0] HALF_TOP =
    odl_pkg::TIMER_BITS'(odl_pkg::SCLK_HALF_CYC - 1);

  assign busy = (state_reg != odl_pkg::HST_IDLE);
  assign tick = (timer_reg == HALF_TOP);
  assign link.frame_sync_n    = frame_n_reg;
  assign link.serial_clock_in = sclk_reg;
  assign link.serial_data_in  = out_reg[odl_pkg::WORD_BITS-1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_reg <= '0;
    end else if (!busy || tick) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_reg + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= odl_pkg::HST_IDLE;
      frame_n_reg   <= 1'b1;
      sclk_reg      <= 1'b1;
      fall_cnt_reg  <= '0;
      frame_len_reg <= odl_pkg::BITS_PER_WORD;
      out_reg       <= odl_pkg::WORD_RST;
      rx_reg        <= odl_pkg::WORD_RST;
    end else begin
      unique case (state_reg)
        odl_pkg::HST_IDLE: begin
          if (start) begin
            // Frame low, MSB on the data line, clock still high
            state_reg     <= odl_pkg::HST_SETUP;
            frame_n_reg   <= 1'b0;
            fall_cnt_reg  <= '0;
            out_reg       <= pwdata[odl_pkg::WORD_BITS-1:0];
            frame_len_reg <= ctrl_reg[odl_pkg::CTRL_LONG_POS] ? odl_pkg::BITS_LONG_WORD
                                                              : odl_pkg::BITS_PER_WORD;
          end
        end
        odl_pkg::HST_SETUP: begin
          if (tick) begin
            state_reg    <= odl_pkg::HST_RUN;
            sclk_reg     <= 1'b0;
            fall_cnt_reg <= fall_cnt_reg + 6'h01;
          end
        end
        odl_pkg::HST_RUN: begin
          if (tick && !sclk_reg) begin
            sclk_reg <= 1'b1;
            out_reg  <= {out_reg[odl_pkg::WORD_BITS-2:0], 1'b0};
            if (fall_cnt_reg > odl_pkg::BITS_PER_WORD) begin
              rx_reg <= {rx_reg[odl_pkg::WORD_BITS-2:0], sdo_sync_reg};
            end
            if (fall_cnt_reg == frame_len_reg) begin
              state_reg <= odl_pkg::HST_HOLD;
            end
          end else if (tick) begin
            sclk_reg     <= 1'b0;
            fall_cnt_reg <= fall_cnt_reg + 6'h01;
          end
        end
        odl_pkg::HST_HOLD: begin
          if (tick) begin
            state_reg   <= odl_pkg::HST_IDLE;
            frame_n_reg <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule
